//--- hdl/alpc_checker.sv
`timescale 1ns/100ps
module alpc_checker
	import alpc_pkg::*;
#(
	parameter int ADDR_W    = 32,
	parameter int PAGE_BITS = 12,
	parameter int ENTRIES   = 4
) (
	input  wire logic                  clk_in,
	input  wire logic                  rst_n_in,
	input  wire logic                  prot_enable_in,
	input  wire logic [1:0]            level_width_field_in,
	input  wire logic                  task_level_wr_in,
	input  wire logic [2:0]            task_level_data_in,
	input  wire logic                  flush_in,
	input  wire logic                  cyc_req_in,
	input  wire logic [ADDR_W-1:0]     cyc_addr_in,
	input  wire logic [FC_W-1:0]       cyc_fc_in,
	input  wire logic                  cyc_write_in,
	input  wire logic                  desc_valid_in,
	input  wire logic                  desc_long_in,
	input  wire logic [2:0]            desc_rl_in,
	input  wire logic [2:0]            desc_wl_in,
	input  wire logic                  desc_wp_in,
	input  wire logic                  desc_invalid_in,
	input  wire logic                  desc_last_in,
	input  wire logic [ADDR_W-PAGE_BITS-1:0] desc_ppage_in,
	output logic                       cyc_busy_out,
	output logic                       cyc_done_out,
	output logic                       cyc_abort_out,
	output logic      [ADDR_W-1:0]     cyc_paddr_out,
	output logic                       search_req_out,
	output logic      [ADDR_W-1:0]     search_addr_out,
	output logic      [FC_W-1:0]       search_fc_out,
	output logic      [2:0]            task_level_out,
	output logic      [2:0]            eff_read_level_out
);
	localparam int PPAGE_W = ADDR_W - PAGE_BITS;
	localparam int TAG_W   = PPAGE_W + FC_W;
	localparam int VIC_W   = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

	alpc_state_t           state_reg;
	logic [ADDR_W-1:0]     addr_reg;
	logic [FC_W-1:0]       fc_reg;
	logic                  write_reg;
	logic                  fault_acc_reg;
	logic                  wp_acc_reg;
	logic [PPAGE_W-1:0]    ppage_acc_reg;
	logic [VIC_W-1:0]      victim_reg;
	logic [2:0]            req_level;
	logic [2:0]            cal_level;
	logic [2:0]            d_rl;
	logic [2:0]            d_wl;
	logic                  active;
	logic                  user_space;
	logic                  cal_violation;
	logic [TAG_W-1:0]      look_tag;
	logic [ENTRIES-1:0]    hit_vec;
	logic [PPAGE_W-1:0]    ent_ppage [ENTRIES];
	logic [ENTRIES-1:0]    ent_fault;
	logic [ENTRIES-1:0]    ent_wp;
	logic                  hit;
	logic [PPAGE_W-1:0]    sel_ppage;
	logic                  sel_fault;
	logic                  sel_wp;
	logic                  fill;
	logic                  desc_take;

	// ==========================================================
	// level decode
	alpc_level_extract #(
		.ADDR_W    (ADDR_W)
	) u_extract (
		.addr_in   (addr_reg),
		.width_in  (level_width_field_in),
		.level_out (req_level)
	);

	// width field of zero means no level bits at all
	assign active     = prot_enable_in && (level_width_field_in != WIDTH_OFF);
	assign user_space = !fc_reg[FC_DMA_BIT] && !fc_reg[FC_SUP_BIT];
	assign cal_level  = alpc_mask(task_level_out, level_width_field_in);
	// unsigned: smaller number asks for more privilege
	assign cal_violation = active && user_space && (req_level < cal_level);
	assign d_rl       = alpc_mask(desc_rl_in, level_width_field_in);
	assign d_wl       = alpc_mask(desc_wl_in, level_width_field_in);
	assign desc_take  = (state_reg == ST_SEARCH) && desc_valid_in;
	assign look_tag   = {fc_reg, addr_reg[ADDR_W-1:PAGE_BITS]};
	assign fill       = (state_reg == ST_FILL);

	// ==========================================================
	// translation cache
	genvar gi;
	generate
		for (gi = 0; gi < ENTRIES; gi++) begin : g_ent
			alpc_cache_entry #(
				.TAG_W         (TAG_W),
				.PPAGE_W       (PPAGE_W)
			) u_ent (
				.clk_in        (clk_in),
				.rst_n_in      (rst_n_in),
				.flush_in      (flush_in),
				.load_in       (fill && (victim_reg == VIC_W'(gi))),
				.load_tag_in   (look_tag),
				.load_ppage_in (ppage_acc_reg),
				.load_fault_in (fault_acc_reg),
				.load_wp_in    (wp_acc_reg),
				.look_tag_in   (look_tag),
				.hit_out       (hit_vec[gi]),
				.ppage_out     (ent_ppage[gi]),
				.fault_out     (ent_fault[gi]),
				.wp_out        (ent_wp[gi])
			);
		end
	endgenerate

	// tags are unique, so an or of the hit lanes is enough
	always_comb begin
		sel_ppage = '0;
		sel_fault = 1'b0;
		sel_wp    = 1'b0;
		for (int i = 0; i < ENTRIES; i++) begin
			if (hit_vec[i]) begin
				sel_ppage = sel_ppage | ent_ppage[i];
				sel_fault = sel_fault | ent_fault[i];
				sel_wp    = sel_wp | ent_wp[i];
			end
		end
	end
	assign hit = |hit_vec;

	// ==========================================================
	// task level register, written by software before dispatch
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			task_level_out <= LVL_RESET;
		end else if (task_level_wr_in) begin
			task_level_out <= task_level_data_in;
		end
	end

	// ==========================================================
	// cycle sequencer
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg      <= ST_IDLE;
			cyc_busy_out   <= 1'b0;
			cyc_done_out   <= 1'b0;
			cyc_abort_out  <= 1'b0;
			search_req_out <= 1'b0;
		end else begin
			cyc_done_out   <= 1'b0;
			cyc_abort_out  <= 1'b0;
			search_req_out <= 1'b0;
			unique case (state_reg)
				ST_IDLE: begin
					if (cyc_req_in) begin
						state_reg    <= ST_CHECK;
						cyc_busy_out <= 1'b1;
					end
				end
				ST_CHECK: begin
					if (cal_violation) begin
						state_reg    <= ST_IDLE;
						cyc_busy_out <= 1'b0;
						cyc_done_out <= 1'b1;
						cyc_abort_out <= 1'b1;
					end else begin
						state_reg <= ST_LOOKUP;
					end
				end
				ST_LOOKUP: begin
					if (hit) begin
						state_reg    <= ST_IDLE;
						cyc_busy_out <= 1'b0;
						cyc_done_out <= 1'b1;
						cyc_abort_out <= sel_fault || (sel_wp && write_reg);
					end else begin
						state_reg      <= ST_SEARCH;
						search_req_out <= 1'b1;
					end
				end
				ST_SEARCH: begin
					if (desc_valid_in && (desc_last_in || desc_invalid_in)) begin
						state_reg <= ST_FILL;
					end
				end
				ST_FILL: begin
					state_reg <= ST_LOOKUP;
				end
			endcase
		end
	end

	// ==========================================================
	// cycle capture and physical address
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			addr_reg        <= '0;
			fc_reg          <= '0;
			write_reg       <= 1'b0;
			search_addr_out <= '0;
			search_fc_out   <= '0;
			cyc_paddr_out   <= '0;
		end else begin
			if (state_reg == ST_IDLE && cyc_req_in) begin
				addr_reg        <= cyc_addr_in;
				fc_reg          <= cyc_fc_in;
				write_reg       <= cyc_write_in;
				search_addr_out <= cyc_addr_in;
				search_fc_out   <= cyc_fc_in;
			end
			if (state_reg == ST_LOOKUP && hit) begin
				cyc_paddr_out <= {sel_ppage, addr_reg[PAGE_BITS-1:0]};
			end
		end
	end

	// ==========================================================
	// table search accumulation
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fault_acc_reg      <= 1'b0;
			wp_acc_reg         <= 1'b0;
			ppage_acc_reg      <= '0;
			eff_read_level_out <= LVL_LOWEST;
		end else if (state_reg == ST_LOOKUP && !hit) begin
			fault_acc_reg      <= 1'b0;
			wp_acc_reg         <= 1'b0;
			eff_read_level_out <= LVL_LOWEST;
		end else if (desc_take) begin
			// level fields only count with protection on; dma too
			if (desc_long_in && active) begin
				if (d_rl < eff_read_level_out) begin
					eff_read_level_out <= d_rl;
				end
				if (d_rl < req_level) begin
					fault_acc_reg <= 1'b1;
				end
				if (d_wl < req_level) begin
					wp_acc_reg <= 1'b1;
				end
			end
			if (desc_wp_in) begin
				wp_acc_reg <= 1'b1;
			end
			if (desc_invalid_in) begin
				fault_acc_reg <= 1'b1;
			end
			if (desc_last_in) begin
				ppage_acc_reg <= desc_ppage_in;
			end
		end
	end

	// round robin victim
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			victim_reg <= '0;
		end else if (fill) begin
			victim_reg <= (victim_reg == VIC_W'(ENTRIES - 1)) ? '0 : victim_reg + 1'b1;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_fill;
		state_reg == ST_FILL;
	endsequence
	sequence s_relookup_hit;
		state_reg == ST_LOOKUP && hit;
	endsequence

	property p_cal_abort;
		state_reg == ST_CHECK && cal_violation |=> cyc_abort_out && cyc_done_out && !cyc_busy_out;
	endproperty
	a_cal_abort: assert property (p_cal_abort) else $error("task level abort missing");

	property p_sup_skip;
		state_reg == ST_CHECK && fc_reg[FC_SUP_BIT] |=> state_reg == ST_LOOKUP;
	endproperty
	a_sup_skip: assert property (p_sup_skip) else $error("supervisor cycle was checked");

	property p_dma_skip;
		state_reg == ST_CHECK && fc_reg[FC_DMA_BIT] |=> state_reg == ST_LOOKUP;
	endproperty
	a_dma_skip: assert property (p_dma_skip) else $error("dma cycle was checked");

	property p_off_skip;
		state_reg == ST_CHECK && !prot_enable_in |=> !cyc_abort_out && state_reg == ST_LOOKUP;
	endproperty
	a_off_skip: assert property (p_off_skip) else $error("check made while disabled");

	property p_hit_fault;
		state_reg == ST_LOOKUP && hit && (sel_fault || (sel_wp && write_reg))
			|=> cyc_abort_out && cyc_done_out;
	endproperty
	a_hit_fault: assert property (p_hit_fault) else $error("cache hit abort missing");

	property p_hit_pass;
		state_reg == ST_LOOKUP && hit && !sel_fault && !(sel_wp && write_reg)
			|=> cyc_done_out && !cyc_abort_out
			&& cyc_paddr_out == {$past(sel_ppage), $past(addr_reg[PAGE_BITS-1:0])};
	endproperty
	a_hit_pass: assert property (p_hit_pass) else $error("hit did not give address");

	property p_miss_search;
		state_reg == ST_LOOKUP && !hit |=> search_req_out && state_reg == ST_SEARCH && !cyc_done_out;
	endproperty
	a_miss_search: assert property (p_miss_search) else $error("miss without search");

	property p_rl_fault;
		desc_take && desc_long_in && active && d_rl < req_level && !desc_last_in
			|=> fault_acc_reg;
	endproperty
	a_rl_fault: assert property (p_rl_fault) else $error("read level fault not set");

	property p_wl_wp;
		desc_take && !desc_last_in && (desc_wp_in || (desc_long_in && active && d_wl < req_level))
			|=> wp_acc_reg;
	endproperty
	a_wl_wp: assert property (p_wl_wp) else $error("write protect not set");

	property p_min_rl;
		desc_take && desc_long_in && active |=> eff_read_level_out <= $past(d_rl);
	endproperty
	a_min_rl: assert property (p_min_rl) else $error("effective read level too high");

	property p_fill_hit;
		s_fill |=> s_relookup_hit ##1 cyc_done_out;
	endproperty
	a_fill_hit: assert property (p_fill_hit) else $error("filled entry did not match");

	property p_extract;
		level_width_field_in == 2'h1 |-> req_level == {2'h0, addr_reg[ADDR_W-1]};
	endproperty
	a_extract: assert property (p_extract) else $error("level bit taken from wrong place");
endmodule : alpc_checker

//--- hdl/alpc_pkg.sv
// Behaviour
// - level width one to three bits
// - zero is most privileged, larger less
// - requested level from top address bits
// - abort reads/writes beyond effective page levels
// - check every long descriptor; keep minimum read
// - user cycles compared against task level
// - passing user cycles go on to translation
// - cache match uses all page address and code bits
// - cache hit: fault, or write-protect on a write, gives bus error
// - cache miss starts a table search
// - read level below request sets fault flag
// - write level below request sets write-protect
// - supervisor cycles skip task level check
// - dma cycles skip task check only; search checks apply
package alpc_pkg;
	// ==========================================================
	// levels and function codes
	localparam int          LVL_W        = 3;
	localparam int          LVL_WIDTH_W  = 2;
	localparam int          FC_W         = 4;
	localparam int          FC_DMA_BIT   = 3;
	localparam int          FC_SUP_BIT   = 2;
	localparam logic [2:0]  LVL_RESET    = 3'h0;
	localparam logic [2:0]  LVL_LOWEST   = 3'h7;
	localparam logic [1:0]  WIDTH_OFF    = 2'h0;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CHECK,
		ST_LOOKUP,
		ST_SEARCH,
		ST_FILL
	} alpc_state_t;

	// ==========================================================
	// keep only the low 'width' bits of a level
	function automatic logic [2:0] alpc_mask(input logic [2:0] lvl, input logic [1:0] width);
		logic [2:0] m;
		m = 3'h0;
		unique case (width)
			2'h1:    m = {2'h0, lvl[0]};
			2'h2:    m = {1'h0, lvl[1:0]};
			2'h3:    m = lvl;
			default: m = 3'h0;
		endcase
		return m;
	endfunction : alpc_mask
endpackage : alpc_pkg

//--- hdl/alpc_level_extract.sv
`timescale 1ns/100ps
module alpc_level_extract
	import alpc_pkg::*;
#(
	parameter int ADDR_W = 32
) (
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [1:0]        width_in,
	output logic      [2:0]        level_out
);
	// ==========================================================
	// requested level sits in the top address bits
	always_comb begin
		unique case (width_in)
			2'h1:    level_out = {2'h0, addr_in[ADDR_W-1]};
			2'h2:    level_out = {1'h0, addr_in[ADDR_W-1 -: 2]};
			2'h3:    level_out = addr_in[ADDR_W-1 -: 3];
			default: level_out = LVL_RESET;
		endcase
	end
endmodule : alpc_level_extract

//--- hdl/alpc_cache_entry.sv
`timescale 1ns/100ps
module alpc_cache_entry
	import alpc_pkg::*;
#(
	parameter int TAG_W   = 24,
	parameter int PPAGE_W = 20
) (
	input  wire logic               clk_in,
	input  wire logic               rst_n_in,
	input  wire logic               flush_in,
	input  wire logic               load_in,
	input  wire logic [TAG_W-1:0]   load_tag_in,
	input  wire logic [PPAGE_W-1:0] load_ppage_in,
	input  wire logic               load_fault_in,
	input  wire logic               load_wp_in,
	input  wire logic [TAG_W-1:0]   look_tag_in,
	output logic                    hit_out,
	output logic      [PPAGE_W-1:0] ppage_out,
	output logic                    fault_out,
	output logic                    wp_out
);
	logic               valid_reg;
	logic [TAG_W-1:0]   tag_reg;

	// ==========================================================
	// entry storage
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			valid_reg <= 1'b0;
		end else if (load_in) begin
			valid_reg <= 1'b1;
		end else if (flush_in) begin
			valid_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tag_reg   <= '0;
			ppage_out <= '0;
			fault_out <= 1'b0;
			wp_out    <= 1'b0;
		end else if (load_in) begin
			tag_reg   <= load_tag_in;
			ppage_out <= load_ppage_in;
			fault_out <= load_fault_in;
			wp_out    <= load_wp_in;
		end
	end

	// every tag bit counts, level and code bits included
	assign hit_out = valid_reg && (tag_reg == look_tag_in);
endmodule : alpc_cache_entry

//--- dv/alpc_table_model.sv
`timescale 1ns/100ps
module alpc_table_model
	import alpc_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        search_req_in,
	output logic             desc_valid_out,
	output logic             desc_long_out,
	output logic [2:0]       desc_rl_out,
	output logic [2:0]       desc_wl_out,
	output logic             desc_wp_out,
	output logic             desc_invalid_out,
	output logic             desc_last_out,
	output logic [19:0]      desc_ppage_out
);
	// ==========================================================
	// table walk answer, set by the bench
	int          cfg_n     = 1;
	int          cfg_delay = 0;
	logic [2:0]  cfg_rl [2];
	logic [2:0]  cfg_wl [2];
	logic        cfg_wp    = 1'b0;
	logic        cfg_inv   = 1'b0;
	logic        cfg_long  = 1'b1;
	logic [19:0] cfg_ppage = 20'h0_0000;

	initial begin
		desc_valid_out   = 1'b0;
		desc_long_out    = 1'b0;
		desc_rl_out      = 3'h0;
		desc_wl_out      = 3'h0;
		desc_wp_out      = 1'b0;
		desc_invalid_out = 1'b0;
		desc_last_out    = 1'b0;
		desc_ppage_out   = 20'h0_0000;
		forever begin
			@(negedge clk_in);
			if (search_req_in) begin
				repeat (cfg_delay) @(negedge clk_in);
				for (int i = 0; i < cfg_n; i++) begin
					desc_valid_out = 1'b1;
					desc_long_out  = cfg_long;
					desc_invalid_out = cfg_inv && (i == cfg_n - 1);
					desc_rl_out    = cfg_rl[i];
					desc_wl_out    = cfg_wl[i];
					desc_wp_out    = cfg_wp;
					desc_last_out  = (i == cfg_n - 1);
					desc_ppage_out = cfg_ppage;
					@(negedge clk_in);
				end
				// released lines: drop valid, last and invalid to zero; invert the rest
				desc_valid_out = 1'b0;
				desc_last_out  = 1'b0;
				desc_invalid_out = 1'b0;
				desc_wp_out    = ~desc_wp_out;
				desc_long_out  = ~desc_long_out;
				desc_rl_out    = ~desc_rl_out;
				desc_wl_out    = ~desc_wl_out;
				desc_ppage_out = ~desc_ppage_out;
			end
		end
	end
endmodule : alpc_table_model

//--- dv/tb_access_level_privilege_checker.sv
`timescale 1ns/100ps
module tb_access_level_privilege_checker;
	import alpc_pkg::*;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        prot = 1'b1;
	logic [1:0]  width = 2'h3;
	logic        tl_wr = 1'b0;
	logic [2:0]  tl_data = 3'h0;
	logic        flush = 1'b0;
	logic        req = 1'b0;
	logic [31:0] addr = 32'h0000_0000;
	logic [3:0]  fc = 4'h0;
	logic        wr = 1'b0;
	logic        dv, dlong, dwp, dinv, dlast;
	logic [2:0]  drl, dwl, tlvl, erl;
	logic [19:0] dpp;
	logic        busy, done, aborted, sreq;
	logic [31:0] paddr, saddr, a;
	logic [3:0]  sfc;
	int          mismatches = 0;
	int          checked = 0;
	int          searches = 0;
	logic        eb_q [$];
	logic [31:0] pa_q [$];

	always #12.5 clk_in = ~clk_in;

	alpc_checker #(.ADDR_W(32), .PAGE_BITS(12), .ENTRIES(4)) dut (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .prot_enable_in(prot),
		.level_width_field_in(width), .task_level_wr_in(tl_wr),
		.task_level_data_in(tl_data), .flush_in(flush), .cyc_req_in(req),
		.cyc_addr_in(addr), .cyc_fc_in(fc), .cyc_write_in(wr), .desc_valid_in(dv),
		.desc_long_in(dlong), .desc_rl_in(drl), .desc_wl_in(dwl), .desc_wp_in(dwp),
		.desc_invalid_in(dinv), .desc_last_in(dlast), .desc_ppage_in(dpp),
		.cyc_busy_out(busy), .cyc_done_out(done), .cyc_abort_out(aborted),
		.cyc_paddr_out(paddr), .search_req_out(sreq), .search_addr_out(saddr),
		.search_fc_out(sfc), .task_level_out(tlvl), .eff_read_level_out(erl));

	alpc_table_model model (
		.clk_in(clk_in), .search_req_in(sreq), .desc_valid_out(dv),
		.desc_long_out(dlong), .desc_rl_out(drl), .desc_wl_out(dwl),
		.desc_wp_out(dwp), .desc_invalid_out(dinv), .desc_last_out(dlast),
		.desc_ppage_out(dpp));

	// ==========================================================
	// checking
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task final_report;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report

	always @(posedge clk_in) if (sreq === 1'b1) searches++;

	// result monitor: oldest note against each done pulse
	always @(negedge clk_in) begin
		if (done === 1'b1) begin
			if (eb_q.size() == 0) begin
				check("unexpected_done", 32'h1, 32'h0);
			end else begin
				check("abort", {31'h0, aborted}, {31'h0, eb_q[0]});
				if (eb_q[0] == 1'b0) check("paddr", paddr, pa_q[0]);
				void'(eb_q.pop_front());
				void'(pa_q.pop_front());
			end
		end
	end

	// ==========================================================
	// stimulus
	task cyc(input logic [31:0] la, input logic [3:0] f, input logic w,
		input logic eb, input logic es);
		int s0;
		int k;
		s0 = searches;
		eb_q.push_back(eb);
		pa_q.push_back({model.cfg_ppage, la[11:0]});
		req = 1'b1;
		addr = la;
		fc = f;
		wr = w;
		@(negedge clk_in);
		req = 1'b0;
		addr = ~la;
		check("busy", {31'h0, busy}, 32'h1);
		k = 0;
		while (done !== 1'b1 && k < 60) begin
			@(negedge clk_in);
			k++;
		end
		check("done_seen", {31'h0, done}, 32'h1);
		check("searched", searches - s0, {31'h0, es});
		if (es) check("search_addr", saddr, la);
		if (es) check("search_fc", {28'h0, sfc}, {28'h0, f});
		check("busy_end", {31'h0, busy}, 32'h0);
		$display("test cycle %h fc %h done", la, f);
	endtask : cyc

	task pg(input logic [2:0] r0, w0, r1, w1, input int n, input logic wp);
		model.cfg_rl[0] = r0;
		model.cfg_wl[0] = w0;
		model.cfg_rl[1] = r1;
		model.cfg_wl[1] = w1;
		model.cfg_n = n;
		model.cfg_wp = wp;
		model.cfg_ppage = 20'($urandom);
	endtask : pg

	task set_task(input logic [2:0] v);
		tl_data = v;
		tl_wr = 1'b1;
		@(negedge clk_in);
		tl_wr = 1'b0;
		@(negedge clk_in);
		check("task_level", {29'h0, tlvl}, {29'h0, v});
	endtask : set_task

	function automatic logic [31:0] la_of(input logic [2:0] lvl);
		return {lvl, 29'($urandom)};
	endfunction : la_of

	initial begin
		#(25ns * 3000);
		mismatches++;
		final_report();
	end

	initial begin
		void'($urandom(11951));
		repeat (6) @(negedge clk_in);
		rst_n_in = 1'b1;
		check("erl_reset", {29'h0, erl}, 32'h7);
		set_task(3'h3);
		cyc(la_of(3'h2), 4'h1, 1'b0, 1'b1, 1'b0);
		pg(3'h3, 3'h3, 3'h7, 3'h7, 1, 1'b0);
		a = la_of(3'h3);
		cyc(a, 4'h1, 1'b0, 1'b0, 1'b1);
		cyc(a, 4'h1, 1'b1, 1'b0, 1'b0);
		a[31:29] = 3'h5;
		pg(3'h4, 3'h6, 3'h7, 3'h7, 1, 1'b0);
		cyc(a, 4'h1, 1'b0, 1'b1, 1'b1);
		cyc(a, 4'h1, 1'b1, 1'b1, 1'b0);
		a = la_of(3'h4);
		pg(3'h6, 3'h2, 3'h7, 3'h7, 1, 1'b0);
		cyc(a, 4'h1, 1'b1, 1'b1, 1'b1);
		cyc(a, 4'h1, 1'b0, 1'b0, 1'b0);
		pg(3'h6, 3'h7, 3'h4, 3'h7, 2, 1'b0);
		model.cfg_delay = 3;
		cyc(la_of(3'h4), 4'h2, 1'b0, 1'b0, 1'b1);
		check("eff_read", {29'h0, erl}, 32'h4);
		model.cfg_delay = 0;
		pg(3'h7, 3'h7, 3'h7, 3'h7, 1, 1'b1);
		cyc(la_of(3'h4), 4'h1, 1'b1, 1'b1, 1'b1);
		pg(3'h0, 3'h0, 3'h7, 3'h7, 1, 1'b0);
		cyc(la_of(3'h0), 4'h5, 1'b0, 1'b0, 1'b1);
		cyc(la_of(3'h0), 4'h9, 1'b1, 1'b0, 1'b1);
		pg(3'h2, 3'h7, 3'h7, 3'h7, 1, 1'b0);
		cyc(la_of(3'h6), 4'h8, 1'b0, 1'b1, 1'b1);
		prot = 1'b0;
		flush = 1'b1;
		@(negedge clk_in);
		flush = 1'b0;
		pg(3'h2, 3'h2, 3'h7, 3'h7, 1, 1'b0);
		cyc(la_of(3'h7), 4'h1, 1'b1, 1'b0, 1'b1);
		cyc(la_of(3'h0), 4'h1, 1'b0, 1'b0, 1'b1);
		prot = 1'b1;
		width = 2'h1;
		set_task(3'h1);
		cyc(la_of(3'h3), 4'h1, 1'b0, 1'b1, 1'b0);
		pg(3'h1, 3'h1, 3'h7, 3'h7, 1, 1'b0);
		cyc(la_of(3'h4), 4'h1, 1'b1, 1'b0, 1'b1);
		width = 2'h3;
		pg(3'h7, 3'h7, 3'h7, 3'h7, 1, 1'b0);
		model.cfg_inv = 1'b1;
		cyc(la_of(3'h4), 4'h1, 1'b0, 1'b1, 1'b1);
		model.cfg_inv = 1'b0;
		model.cfg_long = 1'b0;
		pg(3'h0, 3'h0, 3'h7, 3'h7, 1, 1'b0);
		cyc(la_of(3'h4), 4'h1, 1'b1, 1'b0, 1'b1);
		check("eff_read_short", {29'h0, erl}, 32'h7);
		model.cfg_long = 1'b1;
		width = 2'h2;
		set_task(3'h2);
		cyc(la_of(3'h2), 4'h1, 1'b0, 1'b1, 1'b0);
		width = 2'h0;
		cyc(la_of(3'h0), 4'h1, 1'b1, 1'b0, 1'b1);
		final_report();
	end
endmodule : tb_access_level_privilege_checker
